/* design/tape_word_loader.sv */
// Tape word loader: builds a 40-bit word from ten tape rows and prints a word.
// Assumes reader contacts are raw and may bounce; register port is synchronous.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "tape_word_loader_regs.svh"
module tape_word_loader
    import twl_pkg::*;
#(
    parameter int WORD_W = 40,
    parameter int DEB_CYCLES = `TWL_DEB_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Operation requests
    input wire logic go_enable_i,
    input wire logic input_operate_i,
    input wire logic print_operate_i,
    // Reader
    input wire seg_t seg_raw_i,
    input wire tape_row_t tape_row_i,
    output logic reader_release_o,
    // Indications
    output logic recognize_o,
    output logic tape_end_o,
    // Printer stream
    output logic [3:0] print_char_o,
    output logic print_valid_o,
    input wire logic print_ready_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    seg_t seg_lvl;
    seg_t seg_rise;
    seg_t seg_fall;
    load_state_t state_ff;
    load_state_t nxt_state;
    logic [WORD_W-1:0] target_ff;
    logic [WORD_W-1:0] nxt_target;
    logic [WORD_W-1:0] src_ff;
    logic [5:0] shift_cnt_ff;
    logic [3:0] row_ff;
    logic flag_ff;
    logic release_ff;
    logic tape_end_ff;
    logic tend_seen_ff;
    logic sperr_ff;
    logic [31:0] rdata_ff;
    logic print_busy;

    // Segment contacts, each cleaned by its own debouncer
    genvar gi;
    generate
        for (gi = 0; gi < $bits(seg_t); gi++)
        begin : g_deb
            seg_debounce #(
                .DEB_CYCLES(DEB_CYCLES),
                .CNT_W(($clog2(DEB_CYCLES + 1) < 1) ? 1 : $clog2(DEB_CYCLES + 1))
            ) u_deb (
                .sys_clk_i(sys_clk_i),
                .rst_b_i(rst_b_i),
                .raw_i(seg_raw_i[gi]),
                .lvl_o(seg_lvl[gi]),
                .rise_o(seg_rise[gi]),
                .fall_o(seg_fall[gi])
            );
        end
    endgenerate

    // Request and event decode
    wire idle = state_ff == ST_IDLE;
    wire rows = state_ff == ST_ROWS;
    wire tail = state_ff == ST_TAIL;
    wire start_in = idle && go_enable_i && input_operate_i && !print_busy;
    wire start_pr = idle && go_enable_i && print_operate_i && !input_operate_i && !print_busy;
    wire shift_go = flag_ff != shift_cnt_ff[0];
    wire load_go = rows && seg_rise.num[5] && !shift_go;
    wire last_row = row_ff == (`TWL_ROWS - 4'h1);
    wire tail_sense = tail && seg_rise.num[1];
    // The stop entry that opens the eleventh revolution comes while release is still high;
    // only the stop after the space row, with release already low, ends the input
    wire tail_done = tail && seg_rise.stop && !release_ff;
    wire space_ok = tape_row_i.space_hole && (&tape_row_i.digits);
    // Flag follows segments 1 and 3 only while rows are being read
    wire nxt_flag = rows && (seg_lvl.num[1] || seg_lvl.num[3]);

    // Register decode
    wire wr_ctrl = reg_wr_i && reg_addr_i == `TWL_OFF_CTRL;
    wire wr_src_lo = reg_wr_i && reg_addr_i == `TWL_OFF_SRC_LO;
    wire wr_src_hi = reg_wr_i && reg_addr_i == `TWL_OFF_SRC_HI;
    wire clr_tgt = wr_ctrl && reg_wdata_i[`TWL_CTRL_CLR_TGT] && idle;
    wire clr_sticky = wr_ctrl && reg_wdata_i[`TWL_CTRL_CLR_STICKY];

    // Sequencer: rows until the tenth load, then one tail revolution
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (start_in) nxt_state = ST_ROWS;
            ST_ROWS: if (load_go && last_row) nxt_state = ST_TAIL;
            ST_TAIL: if (tail_done) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Word path: a shift has priority; a load ORs ones into the low digit
    always_comb
    begin
        nxt_target = target_ff;
        if (clr_tgt)
            nxt_target = `TWL_WORD_RST;
        else if (shift_go)
            nxt_target = {target_ff[WORD_W-2:0], 1'b0};
        else if (load_go)
            nxt_target = {target_ff[WORD_W-1:4], target_ff[3:0] | tape_row_i.digits};
    end

    // Sequencer state, flag and counters
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_ff <= ST_IDLE;
            flag_ff <= 1'b0;
            shift_cnt_ff <= 6'h00;
            row_ff <= 4'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            flag_ff <= nxt_flag;
            if (start_in)
                shift_cnt_ff <= 6'h00;
            else if (shift_go)
                shift_cnt_ff <= shift_cnt_ff + 6'h01;
            if (start_in)
                row_ff <= 4'h0;
            else if (load_go && !last_row)
                row_ff <= row_ff + 4'h1;
        end
    end

    // Target word; it only moves while a load runs or on a clear
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            target_ff <= `TWL_WORD_RST;
        else
            target_ff <= nxt_target;
    end

    // Reader release: held for ten rows, dropped once the space row is sensed.
    // The reader itself finishes the revolution, so dropping early is safe.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            release_ff <= 1'b0;
        else if (start_in)
            release_ff <= 1'b1;
        else if (tail_sense || tail_done)
            release_ff <= 1'b0;
    end

    // End pulse and sticky flags; a new event wins over a clear
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            tape_end_ff <= 1'b0;
            tend_seen_ff <= 1'b0;
            sperr_ff <= 1'b0;
        end
        else
        begin
            tape_end_ff <= tail_done;
            tend_seen_ff <= tail_done || (tend_seen_ff && !clr_sticky);
            sperr_ff <= (tail_sense && !space_ok) || (sperr_ff && !clr_sticky);
        end
    end

    // Print source register, written in two parts
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            src_ff <= `TWL_WORD_RST;
        else if (wr_src_lo)
            src_ff[31:0] <= reg_wdata_i;
        else if (wr_src_hi)
            src_ff[WORD_W-1:32] <= reg_wdata_i[WORD_W-33:0];
    end

    print_serializer #(
        .WORD_W(WORD_W),
        .DIG_W(4)
    ) u_print (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(start_pr),
        .src_i(src_ff),
        .char_o(print_char_o),
        .char_valid_o(print_valid_o),
        .char_ready_i(print_ready_i),
        .busy_o(print_busy)
    );

    // Read mux; unmapped offsets read as zero
    wire [31:0] status_word = {10'h000, shift_cnt_ff, 4'h0, row_ff, 2'h0, print_busy, sperr_ff,
                               tend_seen_ff, recognize_o, release_ff, !idle};
    wire [31:0] rd_mux =
        (reg_addr_i == `TWL_OFF_CTRL) ? status_word :
        (reg_addr_i == `TWL_OFF_TGT_LO) ? target_ff[31:0] :
        (reg_addr_i == `TWL_OFF_TGT_HI) ? {{(64-WORD_W){1'b0}}, target_ff[WORD_W-1:32]} :
        (reg_addr_i == `TWL_OFF_SRC_LO) ? src_ff[31:0] :
        (reg_addr_i == `TWL_OFF_SRC_HI) ? {{(64-WORD_W){1'b0}}, src_ff[WORD_W-1:32]} :
        32'h0000_0000;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end

    // Outputs
    assign reg_rdata_o = rdata_ff;
    assign reader_release_o = release_ff;
    assign recognize_o = shift_cnt_ff == `TWL_SHIFTS;
    assign tape_end_o = tape_end_ff;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_flag_rise;
        rows && seg_rise.num[1];
    endsequence

    sequence s_one_shift;
        shift_go ##1 !shift_go;
    endsequence

    a_start_release: assert property (
        start_in |=> release_ff && rows && shift_cnt_ff == 6'h00)
        else $error("start did not release the reader");

    a_flag_shift: assert property (
        s_flag_rise |=> s_one_shift)
        else $error("segment entry did not give exactly one shift");

    a_shift_count: assert property (
        shift_go |=> shift_cnt_ff == $past(shift_cnt_ff) + 6'h01)
        else $error("shift counter did not advance on a shift");

    a_shift_data: assert property (
        shift_go && !clr_tgt |=> target_ff[WORD_W-1:1] == $past(target_ff[WORD_W-2:0]) && !target_ff[0])
        else $error("word did not move up one place");

    a_load_ones: assert property (
        load_go |=> target_ff[3:0] == ($past(target_ff[3:0]) | $past(tape_row_i.digits))
            && target_ff[WORD_W-1:4] == $past(target_ff[WORD_W-1:4]))
        else $error("digit load touched the wrong bits");

    a_four_per_row: assert property (
        load_go |-> shift_cnt_ff == {row_ff, 2'b00} + 6'h04)
        else $error("load without four shifts for this row");

    a_recog_forty: assert property (
        load_go && last_row |-> recognize_o)
        else $error("last load without the recognize indication");

    a_tail_end: assert property (
        tail_done |=> tape_end_o && !release_ff && idle ##1 !tape_end_o)
        else $error("space row did not end the input");

    a_idle_hold: assert property (
        idle && !clr_tgt ##1 idle |-> $stable(target_ff) && !release_ff)
        else $error("word moved or reader released while idle");
endmodule

/* design/tape_word_loader_regs.svh */
// Constants of the tape word loader: register offsets, field positions,
// reset values and timing counts. Included by the loader and the print serializer.
`ifndef TAPE_WORD_LOADER_REGS_SVH
`define TAPE_WORD_LOADER_REGS_SVH

// Clock and debounce timing
`define TWL_CLK_PERIOD_NS 20
`define TWL_DEB_TIME_NS 1000000
`define TWL_DEB_CYCLES ((`TWL_DEB_TIME_NS + `TWL_CLK_PERIOD_NS - 1) / `TWL_CLK_PERIOD_NS)

// Word geometry
`define TWL_ROWS 4'hA
`define TWL_SHIFTS 6'h28
`define TWL_DIGITS 4'hA

// Register byte offsets
`define TWL_OFF_CTRL 8'h00
`define TWL_OFF_TGT_LO 8'h04
`define TWL_OFF_TGT_HI 8'h08
`define TWL_OFF_SRC_LO 8'h0C
`define TWL_OFF_SRC_HI 8'h10

// Control write bits
`define TWL_CTRL_CLR_TGT 0
`define TWL_CTRL_CLR_STICKY 1

// Status read fields
`define TWL_ST_BUSY 0
`define TWL_ST_RELEASE 1
`define TWL_ST_RECOG 2
`define TWL_ST_TEND 3
`define TWL_ST_SPERR 4
`define TWL_ST_PBUSY 5
`define TWL_ST_ROW_LSB 8
`define TWL_ST_CNT_LSB 16

// Reset values
`define TWL_WORD_RST 40'h00_0000_0000

`endif

/* design/twl_pkg.sv */
// Types shared by the tape word loader, its reader model and its testbench.
// Assumes the constants header is compiled alongside.
package twl_pkg;

    // One bit per commutator segment, in brush order
    typedef struct packed {
        logic stop;
        logic start;
        logic [5:1] num;
    } seg_t;

    // One sensed tape row: pin 1 plus four digit pins
    typedef struct packed {
        logic space_hole;
        logic [3:0] digits;
    } tape_row_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ROWS, ST_TAIL} load_state_t;

endpackage

/* design/seg_debounce.sv */
// Synchroniser and debouncer for one reader contact.
// Assumes the contact may bounce for less than DEB_CYCLES clocks.
module seg_debounce #(
    parameter int DEB_CYCLES = 50000,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Raw contact and clean results
    input wire logic raw_i,
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic lvl_ff;
    logic rise_ff;
    logic fall_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic differ;
    logic settled;

    // Only the second stage looks at the first one
    assign differ = sync_ff != lvl_ff;
    assign settled = differ && (cnt_ff == CNT_W'(DEB_CYCLES - 1));

    // A change must hold for the full window, so bounce yields one event
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            lvl_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else
        begin
            meta_ff <= raw_i;
            sync_ff <= meta_ff;
            cnt_ff <= (differ && !settled) ? cnt_ff + 1'b1 : '0;
            lvl_ff <= settled ? sync_ff : lvl_ff;
            rise_ff <= settled && sync_ff;
            fall_ff <= settled && !sync_ff;
        end
    end

    assign lvl_o = lvl_ff;
    assign rise_o = rise_ff;
    assign fall_o = fall_ff;
endmodule

/* design/print_serializer.sv */
// Print path: sends a word as four-bit characters, most significant first.
// Assumes the printer side takes a character when valid and ready meet.
`include "tape_word_loader_regs.svh"
module print_serializer #(
    parameter int WORD_W = 40,
    parameter int DIG_W = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Start and word
    input wire logic start_i,
    input wire logic [WORD_W-1:0] src_i,
    // Character stream
    output logic [DIG_W-1:0] char_o,
    output logic char_valid_o,
    input wire logic char_ready_i,
    output logic busy_o
);
    logic [WORD_W-1:0] word_ff;
    logic [3:0] left_ff;
    logic take;

    assign take = char_valid_o && char_ready_i;

    // The sign digit leaves first; the word moves up one character per take
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            word_ff <= '0;
            left_ff <= 4'h0;
        end
        else if (start_i && left_ff == 4'h0)
        begin
            word_ff <= src_i;
            left_ff <= `TWL_DIGITS;
        end
        else if (take)
        begin
            word_ff <= {word_ff[WORD_W-DIG_W-1:0], {DIG_W{1'b0}}};
            left_ff <= left_ff - 4'h1;
        end
    end

    assign char_o = word_ff[WORD_W-1 -: DIG_W];
    assign char_valid_o = left_ff != 4'h0;
    assign busy_o = char_valid_o;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_print_first_sign: assert property (
        start_i && !busy_o |=> char_o == $past(src_i[WORD_W-1 -: DIG_W]) && left_ff == `TWL_DIGITS)
        else $error("first printed character is not the top digit");
endmodule

/* sim/tape_reader_model.sv */
// Behavioural tape reader: a brush that runs seven segments per tape row.
// Assumes release is a level from the loader, sampled on the system clock.
module tape_reader_model
    import twl_pkg::*;
#(
    parameter logic [39:0] WORD = 40'h00_0000_0000,
    parameter int SEG_LEN = 16
) (
    // Clock
    input wire logic sys_clk_i,
    // Loader side
    input wire logic release_i,
    output seg_t seg_o,
    output tape_row_t row_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int pos = 0;
    int dwell = 0;
    int row = -1;
    logic running = 1'b0;
    logic bounce;
    logic [6:0] clean;

    // Ten digit rows, then the space code that ends the word
    function automatic tape_row_t row_at(input int r);
        if (r < 0)
            return 5'h00;
        if (r >= 10)
            return 5'h1F;
        return {1'b0, WORD[39 - 4 * r -: 4]};
    endfunction

    // Brush position: 0 stop, 1 start, 2 to 6 numbered segments 1 to 5
    always @(posedge sys_clk_i)
    begin
        if (!running)
        begin
            if (release_i === 1'b1)
                running <= 1'b1;
        end
        else if (dwell < SEG_LEN - 1)
            dwell <= dwell + 1;
        else
        begin
            dwell <= 0;
            if (pos == 0)
                row <= row + 1;
            if (pos == 6)
            begin
                pos <= 0;
                running <= (release_i === 1'b1);
            end
            else
                pos <= pos + 1;
        end
    end

    // One-cycle dropout on every segment entry while the brush runs mimics contact bounce
    assign bounce = running && (dwell == 1);
    assign clean = {pos == 0, pos == 1, (pos >= 2) ? 5'h01 << (pos - 2) : 5'h00};
    assign seg_o = bounce ? 7'h00 : clean;
    // Retracted pins read no row: show the inverse so stale data is not trusted
    assign row_o = (pos >= 2) ? row_at(row) : ~row_at(row);
endmodule

/* sim/tape_word_loader_test.sv */
// Testbench of the tape word loader: loads a word from a modelled reader,
// prints a word and checks the register port. Assumes the package is compiled first.
module tape_word_loader_test
    import twl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [39:0] TAPE_WORD = 40'hA5_3C96_0FE1;
    localparam logic [39:0] PRINT_WORD = 40'h91_B2D4_E7F8;

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic go_en = 1'b0;
    logic in_op = 1'b0;
    logic pr_op = 1'b0;
    seg_t seg;
    tape_row_t row;
    logic rel, recog, tend, pvalid;
    logic pready = 1'b0;
    logic [3:0] pchar;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    int err_total = 0;
    int check_count = 0;
    int tend_seen = 0;

    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;

    tape_word_loader #(.DEB_CYCLES(4)) DUT (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .go_enable_i(go_en), .input_operate_i(in_op),
        .print_operate_i(pr_op), .seg_raw_i(seg), .tape_row_i(row), .reader_release_o(rel),
        .recognize_o(recog), .tape_end_o(tend), .print_char_o(pchar), .print_valid_o(pvalid),
        .print_ready_i(pready), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata)
    );

    tape_reader_model #(.WORD(TAPE_WORD), .SEG_LEN(16)) reader (
        .sys_clk_i(sys_clk), .release_i(rel), .seg_o(seg), .row_o(row)
    );

    // The end pulse lasts one cycle, so it is counted as it passes
    always @(posedge sys_clk)
    begin
        if (tend === 1'b1)
            tend_seen <= tend_seen + 1;
    end

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_idle();
        chk("release idle", 1'b0, rel);
        reg_rd(8'h04, d);
        chk("word lo idle", 32'h0000_0000, d);
        reg_rd(8'h08, d);
        chk("word hi idle", 32'h0000_0000, d);
        reg_rd(8'h40, d);
        chk("unmapped read", 32'h0000_0000, d);
        $display("test idle done");
    endtask

    // Input request without go enable must not start the reader
    task automatic t_no_go();
        @(posedge sys_clk);
        in_op <= 1'b1;
        repeat (3) @(posedge sys_clk);
        in_op <= 1'b0;
        #1 chk("release without go", 1'b0, rel);
        $display("test no_go done");
    endtask

    task automatic t_load();
        int i;
        @(posedge sys_clk);
        go_en <= 1'b1;
        in_op <= 1'b1;
        @(posedge sys_clk);
        go_en <= 1'b0;
        in_op <= 1'b0;
        @(posedge sys_clk);
        #1 chk("release on start", 1'b1, rel);
        // A word clear in mid-load must be refused; the final word check would show it
        repeat (600) @(posedge sys_clk);
        reg_wr(8'h00, 32'h0000_0001);
        for (i = 0; i < 3000 && rel === 1'b1; i++)
            @(posedge sys_clk);
        chk("release dropped", 1'b0, rel);
        for (i = 0; i < 1000 && tend_seen == 0; i++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        chk("tape end pulses", 1, tend_seen);
        chk("recognize", 1'b1, recog);
        reg_rd(8'h04, d);
        chk("word lo", TAPE_WORD[31:0], d);
        reg_rd(8'h08, d);
        chk("word hi", {24'h00_0000, TAPE_WORD[39:32]}, d);
        reg_rd(8'h00, d);
        chk("shift count", 6'h28, d[21:16]);
        chk("tape end seen", 1'b1, d[3]);
        chk("space error", 1'b0, d[4]);
        chk("busy after end", 1'b0, d[0]);
        $display("test load done");
    endtask

    task automatic t_print();
        int i;
        reg_wr(8'h0C, PRINT_WORD[31:0]);
        reg_wr(8'h10, {24'h00_0000, PRINT_WORD[39:32]});
        reg_rd(8'h0C, d);
        chk("source lo", PRINT_WORD[31:0], d);
        reg_rd(8'h10, d);
        chk("source hi", {24'h00_0000, PRINT_WORD[39:32]}, d);
        @(posedge sys_clk);
        go_en <= 1'b1;
        pr_op <= 1'b1;
        @(posedge sys_clk);
        go_en <= 1'b0;
        pr_op <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("first char stalled", {1'b1, PRINT_WORD[39:36]}, {pvalid, pchar});
        @(posedge sys_clk);
        pready <= 1'b1;
        #1;
        for (i = 0; i < 10; i++)
        begin
            chk("print char", {1'b1, PRINT_WORD[39 - 4 * i -: 4]}, {pvalid, pchar});
            @(posedge sys_clk);
            #1;
        end
        chk("print done", 1'b0, pvalid);
        pready <= 1'b0;
        $display("test print done");
    endtask

    task automatic t_clear();
        reg_wr(8'h00, 32'h0000_0003);
        reg_rd(8'h04, d);
        chk("word cleared", 32'h0000_0000, d);
        reg_rd(8'h00, d);
        chk("sticky cleared", 1'b0, d[3]);
        $display("test clear done");
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_idle();
        t_no_go();
        t_load();
        t_print();
        t_clear();
        stop_test();
    end

    // Whole run takes about 1300 cycles; this limit leaves wide margin
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end
endmodule
